// ### pkg/lsu_defs.svh
// Constants of the low-speed USB function control block and its host end
`ifndef LSU_DEFS_SVH
`define LSU_DEFS_SVH

// Device register indices (software port address)
`define LSU_A_STATUS     3'h0
`define LSU_A_MASK       3'h1
`define LSU_A_CTL        3'h2
`define LSU_A_NODE       3'h3
`define LSU_A_EP0        3'h4
`define LSU_EP_NUM       3
`define LSU_EP_LAST      2'h2

// Event status and mask bit positions
`define LSU_ST_IDLE      7
`define LSU_ST_DMA       6
`define LSU_ST_GOOD      5
`define LSU_ST_FAULT     4
`define LSU_ST_OVF       3
`define LSU_ST_WAKE      2
`define LSU_ST_RESET     1
`define LSU_ST_SOF       0
`define LSU_STATUS_RESET 8'h00
`define LSU_MASK_RESET   8'h00

// Link control bits
`define LSU_CTL_RESUME   3
`define LSU_CTL_REGOFF   2
`define LSU_CTL_SLEEP    1
`define LSU_CTL_FORCE_BUS_RESET     0
`define LSU_CTL_RESET    4'h6
`define LSU_NODE_RESET   7'h00

// Endpoint transmit control fields
`define LSU_EP_STAGE     7
`define LSU_EP_TOG       6
`define LSU_EP_HS        4
`define LSU_EP_CNT       0
`define LSU_EP_RESET     8'h00

// Timing
`define LSU_CLK_HZ       40000000
`define LSU_IDLE_US      3000
`define LSU_IDLE_CYCLES  (`LSU_IDLE_US * (`LSU_CLK_HZ / 1000000))

// Host command registers and fields
`define LSU_H_LINE       2'h0
`define LSU_H_TOKEN      2'h1
`define LSU_H_EVENT      2'h2
`define LSU_H_STATUS     2'h3
`define LSU_HL_IDLE      0
`define LSU_HL_SE0       1
`define LSU_HL_RESUME    2
`define LSU_HL_TOGBAD    3
`define LSU_HL_OVERRUN   4
`define LSU_HL_RESET     5'h01
`define LSU_HT_ADDR      0
`define LSU_HT_PID       7
`define LSU_HT_EP        9
`define LSU_HT_NZ        11
`define LSU_HT_ERR       12
`define LSU_HE_KEEP      0
`define LSU_HE_ACK       1
`define LSU_HE_CLEAR     2

`endif

// ### pkg/lsu_pkg.sv
// Types shared by both ends of the low-speed USB function link
`default_nettype none
`include "lsu_defs.svh"
package lsu_pkg;
  typedef enum logic [1:0] {
    PID_OUT   = 2'h0,
    PID_IN    = 2'h2,
    PID_SETUP = 2'h3
  } lsu_pid_e;

  typedef enum logic [1:0] {
    ANS_NONE  = 2'h0,
    ANS_ACK   = 2'h1,
    ANS_NAK   = 2'h2,
    ANS_STALL = 2'h3
  } lsu_ans_e;

  typedef enum logic [1:0] {
    HS_OFF   = 2'h0,
    HS_STALL = 2'h1,
    HS_NAK   = 2'h2,
    HS_VALID = 2'h3
  } lsu_hs_e;

  typedef enum logic {
    TX_IDLE     = 1'b0,
    TX_WAIT_ACK = 1'b1
  } lsu_tx_e;

  typedef struct packed {
    logic [7:0]                   status;
    logic [7:0]                   mask;
    logic [3:0]                   ctl;
    logic [6:0]                   node_id;
    logic [`LSU_EP_NUM-1:0][7:0]  ep;
    lsu_tx_e                      tx_st;
    logic [1:0]                   pend_ep;
    logic                         se0_q;
    logic                         force_bus_reset_q;
    logic                         res_q;
    logic                         idle_armed;
    logic                         ans_valid;
    lsu_ans_e                     ans_code;
    logic                         ans_toggle;
    logic [3:0]                   ans_count;
    logic [7:0]                   rd_data;
    logic                         irq;
    logic                         wake_irq;
  } lsu_dev_s;

  typedef struct packed {
    logic [4:0]  line;
    logic        tok_valid;
    logic [6:0]  tok_addr;
    lsu_pid_e    tok_pid;
    logic [1:0]  tok_ep;
    logic        tok_out_nz;
    logic [3:0]  tok_err;
    logic        keep_alive;
    logic        host_ack;
    lsu_ans_e    last_ans;
    logic        last_toggle;
    logic [3:0]  last_count;
    logic        ans_seen;
    logic        resume_seen;
    logic        refused;
    logic [15:0] rd_data;
  } lsu_host_s;
endpackage : lsu_pkg
`default_nettype wire

// ### pkg/lsu_link_if.sv
// Link between the USB function control block and the host end
`default_nettype none
interface lsu_link_if;
  logic               line_idle;
  logic               line_se0;
  logic               line_resume;
  logic               keep_alive;
  logic               tok_valid;
  lsu_pkg::lsu_pid_e  tok_pid;
  logic [1:0]         tok_ep;
  logic [6:0]         tok_addr;
  logic               tok_out_nz;
  logic [3:0]         tok_err;
  logic               tok_toggle_bad;
  logic               tok_overrun;
  logic               host_ack;
  logic               ans_valid;
  lsu_pkg::lsu_ans_e  ans_code;
  logic               ans_toggle;
  logic [3:0]         ans_count;
  logic               dev_resume;
  logic               dev_reg_off;

  modport dev (
    input  line_idle, line_se0, line_resume, keep_alive, tok_valid, tok_pid, tok_ep,
    input  tok_addr, tok_out_nz, tok_err, tok_toggle_bad, tok_overrun, host_ack,
    output ans_valid, ans_code, ans_toggle, ans_count, dev_resume, dev_reg_off
  );
  modport host (
    output line_idle, line_se0, line_resume, keep_alive, tok_valid, tok_pid, tok_ep,
    output tok_addr, tok_out_nz, tok_err, tok_toggle_bad, tok_overrun, host_ack,
    input  ans_valid, ans_code, ans_toggle, ans_count, dev_resume, dev_reg_off
  );
endinterface : lsu_link_if
`default_nettype wire

// ### src/lsu_idle_timer.sv
// Bus idle timer: one pulse after more than LIMIT idle cycles
`default_nettype none
`include "lsu_defs.svh"
module lsu_idle_timer #(
  parameter int unsigned LIMIT = `LSU_IDLE_CYCLES
) (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic enable,
  input  wire logic idle,
  output logic      expired
);
  localparam int unsigned CW = $clog2(LIMIT + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          fired;
    logic          expired;
  } lsu_tmr_s;

  lsu_tmr_s q;
  lsu_tmr_s s;

  // Count idle cycles; fire once per idle stretch
  always_comb begin
    s = q;
    s.expired = 1'b0;
    if (!enable || !idle) begin
      s.count = '0;
      s.fired = 1'b0;
    end else if (q.count != CW'(LIMIT)) begin
      s.count = q.count + 1'b1;
    end else if (!q.fired) begin
      s.fired   = 1'b1;
      s.expired = 1'b1; // LIMIT+1 idle cycles: strictly more than the limit
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= s;
    end
  end

  assign expired = q.expired;
endmodule : lsu_idle_timer
`default_nettype wire

// ### src/lsu_function.sv
// Low-speed USB function control: events, link control, address, endpoint transmit control
// Notes on behaviour
// R1 - Only hardware sets event flags
// R2 - Idle flag after over 3 ms idle
// R3 - DMA late sets its flag
// R4 - Good-transfer flag only for clean, acknowledged transactions
// R5 - Fault flag on timeout, CRC, stuffing, framing
// R6 - Overflow when fault or SOF already set
// R7 - Wake flag on activity during suspend
// R8 - Bus reset: flag, clear address, endpoints
// R9 - SOF flag on keep-alive and resume end
// R10 - Software clears flags by full-byte store
// R11 - Interrupt when flag, mask set, I clear
// R12 - Link control resets 06h, upper zero
// R13 - Resume bit drives resume signalling
// R14 - Power-down bit switches regulator off
// R15 - Force sleep; hardware clears on activity
// R16 - Force reset holds, event on release
// R17 - Seven-bit node address, cleared on reset
// R18 - Status stage stalls nonzero OUT data
// R19 - Toggle set by SETUP, flips on ACK
// R20 - Handshake state: off, stall, nak, valid
// R21 - Good IN or SETUP sets NAK
// R22 - Software keeps transmit count 0 to 8
// R23 - Status write zero clears, one keeps
`default_nettype none
`include "lsu_defs.svh"
module lsu_function #(
  parameter int unsigned IDLE_CYCLES = `LSU_IDLE_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       srst,
  lsu_link_if.dev         lnk,
  input  wire logic [2:0] sw_addr,
  input  wire logic [7:0] sw_wdata,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  output logic      [7:0] sw_rdata,
  input  wire logic       cpu_int_disable,
  input  wire logic       dma_late,
  output logic            irq,
  output logic            wake_irq
);
  lsu_pkg::lsu_dev_s q;
  lsu_pkg::lsu_dev_s s;
  logic              idle_expired;

  // Idle watch runs only while armed
  lsu_idle_timer #(
    .LIMIT (IDLE_CYCLES)
  ) u_idle (
    .clock   (clock),
    .srst    (srst),
    .enable  (q.idle_armed),
    .idle    (lnk.line_idle),
    .expired (idle_expired)
  );

  // Next-state logic for the whole block
  always_comb begin
    logic [7:0]  set;
    logic [7:0]  keep;
    logic        hold_rst;
    logic        res_any;
    logic        res_end;
    logic        accept;
    logic        sleep;
    logic [7:0]  epv;
    logic [2:0]  ridx;
    lsu_pkg::lsu_hs_e hs;
    set      = 8'h00;
    keep     = 8'hff;
    epv      = 8'h00;
    ridx     = 3'h0;
    hs       = lsu_pkg::HS_OFF;
    s        = q;
    s.ans_valid = 1'b0;
    sleep    = q.ctl[`LSU_CTL_SLEEP];
    hold_rst = lnk.line_se0 | q.ctl[`LSU_CTL_FORCE_BUS_RESET]; // R16
    res_any  = q.ctl[`LSU_CTL_RESUME] | lnk.line_resume;
    res_end  = q.res_q & ~res_any;
    accept   = lnk.tok_valid & ~hold_rst & (lnk.tok_addr == q.node_id)
             & (lnk.tok_ep <= `LSU_EP_LAST);

    // Bus reset detect; forced reset raises its event on release
    s.se0_q  = lnk.line_se0;
    s.force_bus_reset_q = q.ctl[`LSU_CTL_FORCE_BUS_RESET];
    if ((lnk.line_se0 && !q.se0_q) || (q.force_bus_reset_q && !q.ctl[`LSU_CTL_FORCE_BUS_RESET])) begin
      set[`LSU_ST_RESET] = 1'b1; // R8 R16
    end

    // Resume ends when neither side still drives it
    s.res_q = res_any;
    if (lnk.keep_alive || res_end) begin
      set[`LSU_ST_SOF] = 1'b1; // R9
    end

    // Activity during suspend wakes the interface
    if (sleep && !lnk.line_idle) begin
      set[`LSU_ST_WAKE] = 1'b1; // R7
      s.ctl[`LSU_CTL_SLEEP] = 1'b0; // R15
    end

    // Idle check: off from forced sleep to resume end, re-armed by reset
    if (sleep) begin
      s.idle_armed = 1'b0; // R2
    end else if (set[`LSU_ST_RESET] || res_end) begin
      s.idle_armed = 1'b1; // R2
    end
    if (idle_expired) begin
      set[`LSU_ST_IDLE] = 1'b1; // R2
    end
    if (dma_late) begin
      set[`LSU_ST_DMA] = 1'b1; // R3
    end

    // A new token while awaiting the host ACK means the ACK timed out
    if (q.tx_st == lsu_pkg::TX_WAIT_ACK) begin
      if (lnk.host_ack) begin
        s.ep[q.pend_ep][`LSU_EP_TOG] = ~q.ep[q.pend_ep][`LSU_EP_TOG]; // R19
        s.ep[q.pend_ep][`LSU_EP_HS +: 2] = lsu_pkg::HS_NAK; // R21
        set[`LSU_ST_GOOD] = 1'b1; // R4
        s.tx_st = lsu_pkg::TX_IDLE;
      end else if (lnk.tok_valid) begin
        set[`LSU_ST_FAULT] = 1'b1; // R5
        s.tx_st = lsu_pkg::TX_IDLE;
      end
    end

    // Token decode; corrupted packets get no answer
    if (accept) begin
      epv = q.ep[lnk.tok_ep];
      hs  = lsu_pkg::lsu_hs_e'(epv[`LSU_EP_HS +: 2]);
      if (|lnk.tok_err) begin
        set[`LSU_ST_FAULT] = 1'b1; // R5
      end else begin
        case (lnk.tok_pid)
          lsu_pkg::PID_SETUP: begin
            s.ans_valid = 1'b1;
            s.ans_code  = lsu_pkg::ANS_ACK;
            s.ep[lnk.tok_ep][`LSU_EP_TOG] = 1'b1; // R19
            if (!lnk.tok_toggle_bad && !lnk.tok_overrun) begin
              set[`LSU_ST_GOOD] = 1'b1; // R4
              s.ep[lnk.tok_ep][`LSU_EP_HS +: 2] = lsu_pkg::HS_NAK; // R21
            end
          end
          lsu_pkg::PID_OUT: begin
            s.ans_valid = 1'b1;
            if (epv[`LSU_EP_STAGE] && lnk.tok_out_nz) begin
              s.ans_code = lsu_pkg::ANS_STALL; // R18
            end else begin
              s.ans_code = lsu_pkg::ANS_ACK; // R18
              if (!lnk.tok_toggle_bad && !lnk.tok_overrun) begin
                set[`LSU_ST_GOOD] = 1'b1; // R4
              end
            end
          end
          lsu_pkg::PID_IN: begin
            case (hs)
              lsu_pkg::HS_STALL: begin
                s.ans_valid = 1'b1;
                s.ans_code  = lsu_pkg::ANS_STALL; // R20
              end
              lsu_pkg::HS_NAK: begin
                s.ans_valid = 1'b1;
                s.ans_code  = lsu_pkg::ANS_NAK; // R20
              end
              lsu_pkg::HS_VALID: begin
                s.ans_valid  = 1'b1;
                s.ans_code   = lsu_pkg::ANS_NONE; // R20
                s.ans_toggle = epv[`LSU_EP_TOG];
                s.ans_count  = epv[`LSU_EP_CNT +: 4];
                s.tx_st      = lsu_pkg::TX_WAIT_ACK;
                s.pend_ep    = lnk.tok_ep;
              end
              default: begin
                s.ans_valid = 1'b0; // R20
              end
            endcase
          end
          default: begin
            s.ans_valid = 1'b0;
          end
        endcase
      end
    end

    // Overflow: fault or SOF raised again before software cleared it
    if ((set[`LSU_ST_FAULT] && q.status[`LSU_ST_FAULT])
        || (set[`LSU_ST_SOF] && q.status[`LSU_ST_SOF])) begin
      set[`LSU_ST_OVF] = 1'b1; // R6
    end

    // Software writes; a status write can only clear, and a new event wins
    if (sw_wr) begin
      case (sw_addr)
        `LSU_A_STATUS: keep = sw_wdata; // R23
        `LSU_A_MASK:   s.mask = sw_wdata;
        `LSU_A_CTL:    s.ctl = sw_wdata[3:0]; // R13 R14 R15 R16
        `LSU_A_NODE:   s.node_id = sw_wdata[6:0]; // R17
        default: begin
          if (sw_addr >= `LSU_A_EP0 && sw_addr <= `LSU_A_EP0 + 3'(`LSU_EP_LAST)) begin
            ridx = sw_addr - `LSU_A_EP0;
            s.ep[ridx[1:0]] = sw_wdata;
          end
        end
      endcase
    end
    s.status = (q.status & keep) | set; // R1 R23

    // Reset holds address and endpoints at their reset values
    if (hold_rst) begin
      s.node_id = `LSU_NODE_RESET; // R17
      s.tx_st   = lsu_pkg::TX_IDLE;
      for (int i = 0; i < `LSU_EP_NUM; i++) begin
        s.ep[i] = `LSU_EP_RESET; // R8
      end
    end

    // Read data stands for the cycle after the strobe only
    s.rd_data = 8'h00;
    if (sw_rd) begin
      case (sw_addr)
        `LSU_A_STATUS: s.rd_data = q.status;
        `LSU_A_MASK:   s.rd_data = q.mask;
        `LSU_A_CTL:    s.rd_data = {4'h0, q.ctl}; // R12
        `LSU_A_NODE:   s.rd_data = {1'b0, q.node_id}; // R17
        default: begin
          if (sw_addr >= `LSU_A_EP0 && sw_addr <= `LSU_A_EP0 + 3'(`LSU_EP_LAST)) begin
            ridx = sw_addr - `LSU_A_EP0;
            s.rd_data = q.ep[ridx[1:0]];
          end
        end
      endcase
    end

    // Wake has its own vector so it can leave halt
    s.irq      = (|(q.status & q.mask & ~(8'h01 << `LSU_ST_WAKE))) & ~cpu_int_disable; // R11
    s.wake_irq = q.status[`LSU_ST_WAKE] & q.mask[`LSU_ST_WAKE] & ~cpu_int_disable; // R11
  end

  // State register with reset values
  always_ff @(posedge clock) begin
    if (srst) begin
      q            <= '0;
      q.status     <= `LSU_STATUS_RESET;
      q.mask       <= `LSU_MASK_RESET;
      q.ctl        <= `LSU_CTL_RESET; // R12
      q.node_id    <= `LSU_NODE_RESET;
      q.tx_st      <= lsu_pkg::TX_IDLE;
      q.ans_code   <= lsu_pkg::ANS_NONE;
    end else begin
      q <= s;
    end
  end

  // Outputs straight from the state register
  assign lnk.ans_valid   = q.ans_valid;
  assign lnk.ans_code    = q.ans_code;
  assign lnk.ans_toggle  = q.ans_toggle;
  assign lnk.ans_count   = q.ans_count;
  assign lnk.dev_resume  = q.ctl[`LSU_CTL_RESUME]; // R13
  assign lnk.dev_reg_off = q.ctl[`LSU_CTL_REGOFF]; // R14
  assign sw_rdata        = q.rd_data;
  assign irq             = q.irq;
  assign wake_irq        = q.wake_irq;
endmodule : lsu_function
`default_nettype wire

// ### src/lsu_host.sv
// Host end of the low-speed USB function link, driven through a command register port
`default_nettype none
`include "lsu_defs.svh"
module lsu_host (
  input  wire logic        clock,
  input  wire logic        srst,
  lsu_link_if.host         lnk,
  input  wire logic [1:0]  cmd_addr,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        cmd_wr,
  input  wire logic        cmd_rd,
  output logic      [15:0] cmd_rdata
);
  lsu_pkg::lsu_host_s q;
  lsu_pkg::lsu_host_s s;

  // Command decode and answer capture
  always_comb begin
    s = q;
    s.tok_valid  = 1'b0;
    s.keep_alive = 1'b0;
    s.host_ack   = 1'b0;
    if (cmd_wr) begin
      case (cmd_addr)
        `LSU_H_LINE: s.line = cmd_wdata[4:0];
        `LSU_H_TOKEN: begin
          // Unpowered device is treated as detached
          if (lnk.dev_reg_off) begin
            s.refused = 1'b1; // R14
          end else begin
            s.tok_valid  = 1'b1;
            s.tok_addr   = cmd_wdata[`LSU_HT_ADDR +: 7];
            s.tok_pid    = lsu_pkg::lsu_pid_e'(cmd_wdata[`LSU_HT_PID +: 2]);
            s.tok_ep     = cmd_wdata[`LSU_HT_EP +: 2];
            s.tok_out_nz = cmd_wdata[`LSU_HT_NZ];
            s.tok_err    = cmd_wdata[`LSU_HT_ERR +: 4];
          end
        end
        `LSU_H_EVENT: begin
          s.keep_alive = cmd_wdata[`LSU_HE_KEEP];
          s.host_ack   = cmd_wdata[`LSU_HE_ACK];
          if (cmd_wdata[`LSU_HE_CLEAR]) begin
            s.ans_seen    = 1'b0;
            s.resume_seen = 1'b0;
            s.refused     = 1'b0;
          end
        end
        default: begin
          s.line = q.line;
        end
      endcase
    end
    // Captures win over a same-cycle clear
    if (lnk.ans_valid) begin
      s.ans_seen    = 1'b1;
      s.last_ans    = lnk.ans_code;
      s.last_toggle = lnk.ans_toggle;
      s.last_count  = lnk.ans_count;
    end
    if (lnk.dev_resume) begin
      s.resume_seen = 1'b1; // R13
    end
    s.rd_data = 16'h0000;
    if (cmd_rd && cmd_addr == `LSU_H_STATUS) begin
      s.rd_data = {5'h00, q.refused, lnk.dev_reg_off, q.ans_seen, q.resume_seen,
                   q.last_count, q.last_toggle, q.last_ans};
    end else if (cmd_rd && cmd_addr == `LSU_H_LINE) begin
      s.rd_data = {11'h000, q.line};
    end
  end

  // State register
  always_ff @(posedge clock) begin
    if (srst) begin
      q          <= '0;
      q.line     <= `LSU_HL_RESET;
      q.tok_pid  <= lsu_pkg::PID_OUT;
      q.last_ans <= lsu_pkg::ANS_NONE;
    end else begin
      q <= s;
    end
  end

  // Link drive; leaving idle is the activity that ends device sleep
  assign lnk.line_idle      = q.line[`LSU_HL_IDLE]; // R15
  assign lnk.line_se0       = q.line[`LSU_HL_SE0];
  assign lnk.line_resume    = q.line[`LSU_HL_RESUME];
  assign lnk.tok_toggle_bad = q.line[`LSU_HL_TOGBAD];
  assign lnk.tok_overrun    = q.line[`LSU_HL_OVERRUN];
  assign lnk.keep_alive     = q.keep_alive;
  assign lnk.tok_valid      = q.tok_valid;
  assign lnk.tok_pid        = q.tok_pid;
  assign lnk.tok_ep         = q.tok_ep;
  assign lnk.tok_addr       = q.tok_addr;
  assign lnk.tok_out_nz     = q.tok_out_nz;
  assign lnk.tok_err        = q.tok_err;
  assign lnk.host_ack       = q.host_ack;
  assign cmd_rdata          = q.rd_data;
endmodule : lsu_host
`default_nettype wire

// ### verif/lsu_link_props.sv
// Link checker for the USB function control block and its host end
`default_nettype none
module lsu_link_props (
  input wire logic              clock,
  input wire logic              srst,
  input wire logic              line_se0,
  input wire logic              tok_valid,
  input wire lsu_pkg::lsu_pid_e tok_pid,
  input wire logic              tok_out_nz,
  input wire logic [3:0]        tok_err,
  input wire logic              ans_valid,
  input wire lsu_pkg::lsu_ans_e ans_code,
  input wire logic              ans_toggle,
  input wire logic [3:0]        ans_count,
  input wire logic              dev_resume,
  input wire logic              dev_reg_off
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  // Answers come one cycle after a token, never on their own
  property p_after_token;
    ans_valid |-> $past(tok_valid);
  endproperty
  a_after_token: assert property (p_after_token) else $error("answer without token");
  // Corrupted tokens stay unanswered
  property p_fault_quiet;
    tok_valid && (tok_err != 4'h0) |=> !ans_valid;
  endproperty
  a_fault_quiet: assert property (p_fault_quiet) else $error("faulty token answered");
  // Held bus reset hides the function
  property p_reset_quiet;
    tok_valid && line_se0 |=> !ans_valid;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("answer in bus reset");
  // OUT data is only acked or stalled
  property p_out_kind;
    ans_valid && ($past(tok_pid) == lsu_pkg::PID_OUT)
      |-> ans_code inside {lsu_pkg::ANS_ACK, lsu_pkg::ANS_STALL};
  endproperty
  a_out_kind: assert property (p_out_kind) else $error("bad OUT answer");
  // Zero-length OUT is never stalled
  property p_out_zero;
    ans_valid && ($past(tok_pid) == lsu_pkg::PID_OUT) && !$past(tok_out_nz)
      |-> ans_code == lsu_pkg::ANS_ACK;
  endproperty
  a_out_zero: assert property (p_out_zero) else $error("zero OUT stalled");
  // SETUP always acked
  property p_setup_ack;
    ans_valid && ($past(tok_pid) == lsu_pkg::PID_SETUP) |-> ans_code == lsu_pkg::ANS_ACK;
  endproperty
  a_setup_ack: assert property (p_setup_ack) else $error("SETUP not acked");
  // Answer fields stand until the next answer
  property p_hold;
    !ans_valid |-> $stable(ans_code) && $stable(ans_toggle) && $stable(ans_count);
  endproperty
  a_hold: assert property (p_hold) else $error("answer fields moved");
  // Regulator off and no resume after reset
  property p_wake_up;
    $fell(srst) |-> dev_reg_off && !dev_resume;
  endproperty
  a_wake_up: assert property (p_wake_up) else $error("link control not at reset");
endmodule : lsu_link_props
`default_nettype wire

// ### verif/test_lowspeed_usb_function_ctrl.sv
// Self-checking bench for the USB function control block and its host end
`default_nettype none
module test_lowspeed_usb_function_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock;
  logic        srst;
  logic [2:0]  sw_addr;
  logic [7:0]  sw_wdata;
  logic        sw_wr;
  logic        sw_rd;
  logic [7:0]  sw_rdata;
  logic        cpu_int_disable;
  logic        dma_late;
  logic        irq;
  logic        wake_irq;
  logic [1:0]  cmd_addr;
  logic [15:0] cmd_wdata;
  logic        cmd_wr;
  logic        cmd_rd;
  logic [15:0] cmd_rdata;
  int          fail_count;
  int          num_checks;
  int          cycles;
  logic [7:0]  rst_val [8] = '{8'h00, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [15:0] hexp [3] = '{16'h0000, 16'h0103, 16'h0102};

  lsu_link_if lsu_link_if_inst ();
  // Short idle limit keeps the run brief
  lsu_function #(.IDLE_CYCLES(20)) lsu_function_inst (
    .clock(clock), .srst(srst), .lnk(lsu_link_if_inst.dev), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .cpu_int_disable(cpu_int_disable), .dma_late(dma_late), .irq(irq), .wake_irq(wake_irq)
  );
  lsu_host lsu_host_inst (
    .clock(clock), .srst(srst), .lnk(lsu_link_if_inst.host), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata)
  );
  lsu_link_props lsu_link_props_inst (
    .clock(clock), .srst(srst), .line_se0(lsu_link_if_inst.line_se0),
    .tok_valid(lsu_link_if_inst.tok_valid), .tok_pid(lsu_link_if_inst.tok_pid),
    .tok_out_nz(lsu_link_if_inst.tok_out_nz), .tok_err(lsu_link_if_inst.tok_err),
    .ans_valid(lsu_link_if_inst.ans_valid), .ans_code(lsu_link_if_inst.ans_code),
    .ans_toggle(lsu_link_if_inst.ans_toggle), .ans_count(lsu_link_if_inst.ans_count),
    .dev_resume(lsu_link_if_inst.dev_resume), .dev_reg_off(lsu_link_if_inst.dev_reg_off)
  );

  // Clock and hang guard
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count = fail_count + 1;
      close_out();
    end
  end

  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk8
  task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk16
  // Device port: one-cycle strobes, read data in the next cycle only
  task automatic dw(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    sw_addr  <= a;
    sw_wdata <= d;
    sw_wr    <= 1'b1;
    @(posedge clock);
    sw_wr <= 1'b0;
  endtask : dw
  task automatic dr(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock);
    sw_addr <= a;
    sw_rd   <= 1'b1;
    @(posedge clock);
    sw_rd <= 1'b0;
    #1;
    chk8("dev reg", e, sw_rdata);
  endtask : dr
  task automatic hw(input logic [1:0] a, input logic [15:0] d);
    @(posedge clock);
    cmd_addr  <= a;
    cmd_wdata <= d;
    cmd_wr    <= 1'b1;
    @(posedge clock);
    cmd_wr <= 1'b0;
  endtask : hw
  // Host status under a mask, since some bits are sticky
  task automatic hs(input logic [15:0] m, input logic [15:0] e);
    @(posedge clock);
    cmd_addr <= 2'h3;
    cmd_rd   <= 1'b1;
    @(posedge clock);
    cmd_rd <= 1'b0;
    #1;
    chk16("host status", e, cmd_rdata & m);
  endtask : hs
  // Token after clearing host stickies; answer lands two cycles on
  task automatic tk(input logic [15:0] t);
    hw(2'h2, 16'h0004);
    hw(2'h1, t);
    repeat (3) @(posedge clock);
  endtask : tk
  task automatic close_out();
    if (fail_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    srst = 1'b1;
    {sw_addr, sw_wdata, sw_wr, sw_rd, cpu_int_disable, dma_late} = '0;
    {cmd_addr, cmd_wdata, cmd_wr, cmd_rd} = '0;
    fail_count = 0;
    num_checks = 0;
    cycles = 0;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) dr(i[2:0], rst_val[i]);
    chk8("reg off", 8'h01, {7'h00, lsu_link_if_inst.dev_reg_off});
    tk(16'h0100);
    hs(16'h0700, 16'h0600);
    hw(2'h0, 16'h0000);
    dw(3'h2, 8'hf8);
    dr(3'h2, 8'h08);
    chk8("resume", 8'h01, {7'h00, lsu_link_if_inst.dev_resume});
    chk8("reg off", 8'h00, {7'h00, lsu_link_if_inst.dev_reg_off});
    dw(3'h2, 8'h00);
    dr(3'h0, 8'h05);
    dw(3'h0, 8'hff);
    dr(3'h0, 8'h05);
    dw(3'h0, 8'hfe);
    dr(3'h0, 8'h04);
    hw(2'h2, 16'h0001);
    hw(2'h2, 16'h0001);
    dr(3'h0, 8'h0d);
    dw(3'h0, 8'h00);
    @(posedge clock);
    dma_late <= 1'b1;
    @(posedge clock);
    dma_late <= 1'b0;
    dr(3'h0, 8'h40);
    dw(3'h0, 8'h00);
    // Address width, then forced reset hold and release
    dw(3'h3, 8'hff);
    dr(3'h3, 8'h7f);
    dw(3'h2, 8'h01);
    dw(3'h3, 8'h05);
    dr(3'h3, 8'h00);
    dw(3'h2, 8'h00);
    dr(3'h0, 8'h02);
    dw(3'h0, 8'h00);
    // Bus reset from the line clears address and endpoints
    dw(3'h3, 8'h05);
    dw(3'h4, 8'h35);
    hw(2'h0, 16'h0002);
    tk(16'h0100);
    hs(16'h0100, 16'h0000);
    hw(2'h0, 16'h0000);
    dr(3'h3, 8'h00);
    dr(3'h4, 8'h00);
    dr(3'h0, 8'h02);
    dw(3'h0, 8'h00);
    // IN data on ep1, then host ack
    dw(3'h3, 8'h05);
    dw(3'h1, 8'h24);
    dw(3'h5, 8'h35);
    tk(16'h0305);
    hs(16'h017f, 16'h0128);
    hw(2'h2, 16'h0002);
    repeat (2) @(posedge clock);
    dr(3'h5, 8'h65);
    dr(3'h0, 8'h20);
    chk8("irq", 8'h01, {7'h00, irq});
    @(posedge clock);
    cpu_int_disable <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    chk8("irq", 8'h00, {7'h00, irq});
    cpu_int_disable <= 1'b0;
    dw(3'h0, 8'h00);
    // Handshake states off, stall, nak
    for (int i = 0; i < 3; i++) begin
      dw(3'h5, {2'b00, i[1:0], 4'h5});
      tk(16'h0305);
      hs(16'h0103, hexp[i]);
    end
    // Status stage on ep2
    dw(3'h6, 8'h80);
    tk(16'h0c05);
    hs(16'h0103, 16'h0103);
    tk(16'h0405);
    hs(16'h0103, 16'h0101);
    dr(3'h0, 8'h20);
    dw(3'h0, 8'h00);
    hw(2'h0, 16'h0008);
    tk(16'h0405);
    hw(2'h0, 16'h0000);
    dr(3'h0, 8'h00);
    // SETUP on ep0
    tk(16'h0185);
    hs(16'h0103, 16'h0101);
    dr(3'h4, 8'h60);
    dr(3'h0, 8'h20);
    dw(3'h0, 8'h00);
    // Foreign address, then two faults
    tk(16'h0306);
    hs(16'h0100, 16'h0000);
    tk(16'h1305);
    tk(16'h1305);
    hs(16'h0100, 16'h0000);
    dr(3'h0, 8'h18);
    dw(3'h0, 8'h00);
    // Idle flag not early, then set
    hw(2'h0, 16'h0001);
    repeat (12) @(posedge clock);
    dr(3'h0, 8'h00);
    repeat (12) @(posedge clock);
    dr(3'h0, 8'h80);
    dw(3'h0, 8'h00);
    // Forced sleep ended by bus activity
    dw(3'h2, 8'h02);
    hw(2'h0, 16'h0000);
    dr(3'h2, 8'h00);
    dr(3'h0, 8'h04);
    chk8("wake irq", 8'h01, {7'h00, wake_irq});
    chk8("irq", 8'h00, {7'h00, irq});
    close_out();
  end
endmodule : test_lowspeed_usb_function_ctrl
`default_nettype wire
